// ### hw/sft_pkg.sv
// package for the static ram functional pattern tester
package sft_pkg;

  localparam int unsigned ADDR_W      = 21;            // 2M locations
  localparam int unsigned DATA_W      = 8;
  localparam logic [20:0] MAX_ADDR_RST = 21'h1FFFFF;   // default highest address
  localparam logic [7:0]  CHK_DATA    = 8'h55;         // checkerboard seed
  localparam logic [7:0]  MARCH_DATA  = 8'h55;
  localparam logic [7:0]  ZERO_DATA   = 8'h00;
  localparam logic [7:0]  ONES_DATA   = 8'hFF;
  // memory access time 25 ns at 5 ns per cycle, rounded up
  localparam int unsigned ACC_NS      = 25;
  localparam int unsigned CLK_NS      = 5;
  localparam logic [3:0]  ACC_CYC     = 4'((ACC_NS + CLK_NS - 1) / CLK_NS);

  // pattern family selection
  typedef enum logic [2:0] {
    SFT_PAT_CHK   = 3'h0,
    SFT_PAT_MARCH = 3'h1,
    SFT_PAT_SOLID = 3'h2,
    SFT_PAT_OE    = 3'h3,
    SFT_PAT_CS    = 3'h4
  } sft_pat_e;

  // memory pins, outputs of the engine
  typedef struct packed {
    logic [20:0] addr;
    logic [7:0]  wdata;
    logic        data_oe_n;          // low while engine drives data
    logic        write_low;
    logic        output_enable_low;
    logic        chip_select_low;
  } sft_mem_s;

  // captured failure record
  typedef struct packed {
    logic [20:0] addr;
    logic [7:0]  expected;
    logic [7:0]  observed;
  } sft_fail_s;

endpackage : sft_pkg

// ### hw/sft_tester.sv
// pattern engine driving an 8-bit asynchronous static ram
`timescale 1ns/10ps
module sft_tester
  import sft_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        start_i,
  input  wire sft_pat_e    pattern_i,
  input  wire logic [20:0] max_addr_i,
  input  wire logic        clear_fail_i,
  // memory pins
  output sft_mem_s         mem_o,
  input  wire logic [7:0]  mem_data_i,
  input  wire logic        mem_data_z_i,     // high when data lines float
  // status
  output logic             busy_o,
  output logic             done_o,
  output logic             fail_o,
  output sft_fail_s        fail_info_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_WRITE = 3'h2,
    ST_READ  = 3'h3,
    ST_NEXT  = 3'h4
  } sft_state_e;

  sft_state_e   state_r, state_nxt;
  sft_pat_e     pat_r, pat_nxt;
  logic [2:0]   phase_r, phase_nxt;   // step inside the pattern
  logic [1:0]   op_r, op_nxt;         // operation inside one address
  logic [20:0]  addr_r, addr_nxt;
  logic [3:0]   wait_r, wait_nxt;
  logic [7:0]   exp_r, exp_nxt;
  logic         done_r, done_nxt;
  logic         fail_r, fail_nxt;
  sft_fail_s    finfo_r, finfo_nxt;
  sft_mem_s     mem_r, mem_nxt;
  logic [20:0]  top;
  logic         last_addr, descend;
  logic         is_write, last_op, last_phase;
  logic [7:0]   pat_byte;
  logic [20:0]  phys_addr;
  logic         mism;
  // synchroniser for asynchronous read data from the pins
  logic [8:0]   s1_r, s2_r, s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage sampling; a value counts once stages two and three agree
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s1_r <= 9'h000;
      s2_r <= 9'h000;
      s3_r <= 9'h000;
    end
    else
    begin
      s1_r <= {mem_data_z_i, mem_data_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence decoding
  assign top = max_addr_i;
  // march steps three to six walk downward
  assign descend   = (pat_r == SFT_PAT_MARCH) && (phase_r >= 3'h2);
  // control checks make one access at address zero only
  assign last_addr = ((pat_r == SFT_PAT_OE) || (pat_r == SFT_PAT_CS)) ? 1'b1 :
                     descend ? (addr_r == 21'h000000) : (addr_r == top);
  // one-bit rotate right puts logical address bit 0 on physical address bit 20
  assign phys_addr = {addr_r[0], addr_r[20:1]};

  // what the current phase/op does and when the phase/pattern ends
  always_comb
  begin
    is_write   = 1'b0;
    last_op    = 1'b1;
    last_phase = 1'b0;
    pat_byte   = ZERO_DATA;
    unique case (pat_r)
      SFT_PAT_CHK:
      begin
        is_write   = ~phase_r[0];
        last_phase = (phase_r == 3'h3);
        pat_byte   = (addr_r[0] ^ phase_r[1]) ? ~CHK_DATA : CHK_DATA;
      end
      SFT_PAT_MARCH:
      begin
        unique case (phase_r)
          3'h0: is_write = 1'b1;
          3'h1, 3'h3:
          begin
            is_write = op_r[0];
            last_op  = (op_r == 2'h1);
          end
          3'h2, 3'h4:
          begin
            is_write = op_r[0];
            last_op  = (op_r == 2'h3);
          end
          default: is_write = 1'b0;
        endcase
        last_phase = (phase_r == 3'h5);
        // per-phase/op value, the same at every address within a phase
        pat_byte   = MARCH_DATA;
        if (((phase_r == 3'h2) && !op_r[1]) || (phase_r == 3'h3) ||
            ((phase_r == 3'h4) && op_r[1]))
          pat_byte = ~MARCH_DATA;
      end
      SFT_PAT_SOLID:
      begin
        is_write   = ~phase_r[0];
        last_phase = (phase_r == 3'h3);
        pat_byte   = phase_r[1] ? ONES_DATA : ZERO_DATA;
      end
      default:
      begin
        last_phase = 1'b1;                                // one access only
      end
    endcase
  end

  // read verify, data or float depending on pattern
  always_comb
  begin
    if ((pat_r == SFT_PAT_OE) || (pat_r == SFT_PAT_CS))
      mism = ~s3_r[8] || (s2_r != s3_r);
    else
      mism = (s3_r[7:0] != exp_r) || (s2_r != s3_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state and pin values
  always_comb
  begin
    state_nxt = state_r;
    pat_nxt   = pat_r;
    phase_nxt = phase_r;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    wait_nxt  = wait_r;
    exp_nxt   = exp_r;
    done_nxt  = done_r;
    fail_nxt  = fail_r;
    finfo_nxt = finfo_r;
    mem_nxt   = mem_r;
    if (clear_fail_i)
      fail_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        mem_nxt.write_low         = 1'b1;
        mem_nxt.output_enable_low = 1'b1;
        mem_nxt.chip_select_low   = 1'b1;
        mem_nxt.data_oe_n         = 1'b1;
        if (start_i)
        begin
          pat_nxt   = pattern_i;
          phase_nxt = 3'h0;
          op_nxt    = 2'h0;
          addr_nxt  = 21'h000000;
          done_nxt  = 1'b0;
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // address, data and strobes all load on the same edge at the start of each access
        mem_nxt.addr              = phys_addr;
        mem_nxt.write_low         = 1'b1;
        mem_nxt.output_enable_low = 1'b1;
        mem_nxt.chip_select_low   = 1'b1;
        wait_nxt                  = ACC_CYC;
        if ((pat_r == SFT_PAT_OE) || (pat_r == SFT_PAT_CS))
        begin
          // each control check is its own single access
          mem_nxt.data_oe_n         = 1'b1;
          wait_nxt                  = ACC_CYC + 4'h3;      // synchroniser delay
          mem_nxt.chip_select_low   = (pat_r == SFT_PAT_OE) ? 1'b0 : 1'b1;
          mem_nxt.output_enable_low = (pat_r == SFT_PAT_CS) ? 1'b0 : 1'b1;
          state_nxt = ST_READ;
        end
        else if (is_write)
        begin
          // march complements what the previous access saw
          mem_nxt.wdata     = (pat_r == SFT_PAT_MARCH && phase_r != 3'h0) ? ~pat_byte : pat_byte;
          mem_nxt.data_oe_n = 1'b0;
          mem_nxt.chip_select_low = 1'b0;
          mem_nxt.write_low = 1'b0;
          state_nxt = ST_WRITE;
        end
        else
        begin
          exp_nxt  = pat_byte;
          wait_nxt = ACC_CYC + 4'h3;                      // synchroniser delay
          mem_nxt.data_oe_n         = 1'b1;
          mem_nxt.chip_select_low   = 1'b0;
          mem_nxt.output_enable_low = 1'b0;
          state_nxt = ST_READ;
        end
      end
      ST_WRITE:
      begin
        wait_nxt = wait_r - 4'h1;
        if (wait_r == 4'h0)
        begin
          mem_nxt.write_low       = 1'b1;
          mem_nxt.chip_select_low = 1'b1;
          state_nxt = ST_NEXT;
        end
      end
      ST_READ:
      begin
        // extra three cycles cover the input synchroniser
        wait_nxt = wait_r - 4'h1;
        if (wait_r == 4'h0)
        begin
          if (mism && !fail_r)
          begin
            fail_nxt       = 1'b1;
            finfo_nxt.addr = addr_r;
            finfo_nxt.expected = exp_r;
            finfo_nxt.observed = s3_r[7:0];
          end
          else if (mism)
            fail_nxt = 1'b1;
          mem_nxt.output_enable_low = 1'b1;
          mem_nxt.chip_select_low   = 1'b1;
          state_nxt = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        state_nxt = ST_SETUP;
        if (!last_op)
          op_nxt = op_r + 2'h1;
        else
        begin
          op_nxt = 2'h0;
          if (!last_addr)
            addr_nxt = descend ? addr_r - 21'h000001 : addr_r + 21'h000001;
          else if (!last_phase)
          begin
            phase_nxt = phase_r + 3'h1;
            // step three onward starts from the top
            addr_nxt  = (pat_r == SFT_PAT_MARCH && phase_r >= 3'h1) ? top : 21'h000000;
          end
          else
          begin
            done_nxt  = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      pat_r   <= SFT_PAT_CHK;
      phase_r <= 3'h0;
      op_r    <= 2'h0;
      addr_r  <= 21'h000000;
      wait_r  <= 4'h0;
      exp_r   <= ZERO_DATA;
      done_r  <= 1'b0;
      fail_r  <= 1'b0;
      finfo_r <= '0;
      mem_r   <= '{addr: 21'h000000, wdata: 8'h00, data_oe_n: 1'b1,
                   write_low: 1'b1, output_enable_low: 1'b1, chip_select_low: 1'b1};
    end
    else
    begin
      state_r <= state_nxt;
      pat_r   <= pat_nxt;
      phase_r <= phase_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      wait_r  <= wait_nxt;
      exp_r   <= exp_nxt;
      done_r  <= done_nxt;
      fail_r  <= fail_nxt;
      finfo_r <= finfo_nxt;
      mem_r   <= mem_nxt;
    end
  end

  // outputs
  assign mem_o       = mem_r;
  assign busy_o      = (state_r != ST_IDLE);
  assign done_o      = done_r;
  assign fail_o      = fail_r;
  assign fail_info_o = finfo_r;

endmodule : sft_tester

// ### tb/sft_props.sv
// port checks for the pattern engine
`timescale 1ns/10ps
module sft_props
  import sft_pkg::*;
(
  // clock, reset, control
  input wire logic      mclk_i,
  input wire logic      rst_i,
  input wire logic      start_i,
  input wire logic      clear_fail_i,
  // engine outputs
  input wire sft_mem_s  mem_o,
  input wire logic      busy_o,
  input wire logic      done_o,
  input wire logic      fail_o,
  input wire sft_fail_s fail_info_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // write and select strobes, data drive and status quiet right after reset
  chk_reset_quiet: assert property ($past(rst_i) |-> mem_o.write_low && mem_o.chip_select_low
    && mem_o.data_oe_n && !busy_o && !done_o && !fail_o) else $error("not quiet after reset");
  chk_write_select: assert property (!mem_o.write_low |-> !mem_o.chip_select_low
    && !mem_o.data_oe_n && mem_o.output_enable_low) else $error("bad write strobes");
  // engine must let go of the bus during reads, else it fights the ram
  chk_read_clash: assert property (!mem_o.output_enable_low && !mem_o.chip_select_low
    |-> mem_o.data_oe_n) else $error("bus clash on read");
  chk_write_hold: assert property ($fell(mem_o.write_low) |=>
    (!mem_o.write_low && $stable(mem_o.addr) && $stable(mem_o.wdata))[*4]) else $error("short write");
  chk_read_hold: assert property ($fell(mem_o.output_enable_low) |=>
    (!mem_o.output_enable_low && $stable(mem_o.addr))[*7]) else $error("short read");
  chk_busy_answer: assert property (!busy_o && start_i |=> busy_o) else $error("start lost");
  chk_done_stands: assert property (done_o && !start_i |=> done_o) else $error("done dropped");
  chk_done_idle: assert property (done_o |-> !busy_o && mem_o.write_low) else $error("done busy");
  chk_fail_sticky: assert property (fail_o && !clear_fail_i |=> fail_o) else $error("fail lost");
  chk_info_frozen: assert property (fail_o && !clear_fail_i |=> $stable(fail_info_o))
    else $error("failure record changed");
  // main scenarios reached
  cover property ($rose(done_o));
  cover property ($rose(fail_o));
  cover property (busy_o && start_i);
endmodule : sft_props
bind sft_tester sft_props u_sft_props (.mclk_i, .rst_i, .start_i, .clear_fail_i, .mem_o, .busy_o,
  .done_o, .fail_o, .fail_info_o);

// ### tb/sft_ram_model.sv
// behavioural asynchronous byte-wide static ram on the far side
`timescale 1ns/10ps
module sft_ram_model
  import sft_pkg::*;
(
  // pins from the engine
  input  wire sft_mem_s    mem_i,
  // fault injection
  input  wire logic [20:0] bad_addr_i,
  input  wire logic        bad_en_i,
  input  wire logic        stuck_i,
  // data bus
  output logic [7:0]       dq_o,
  output logic             dq_z_o
);
  logic [7:0] mem_r [logic [20:0]];
  logic [7:0] last_r = 8'h00;
  logic       drv;
  // level write while strobe and select are low, like the real array
  always @*
    if (!mem_i.write_low && !mem_i.chip_select_low)
      mem_r[mem_i.addr] = mem_i.wdata;
  // read drive; a released bus shows the inverse, never a stale byte
  always @*
  begin
    drv = stuck_i || (!mem_i.chip_select_low && !mem_i.output_enable_low && mem_i.write_low);
    if (drv)
      last_r = (mem_r.exists(mem_i.addr) ? mem_r[mem_i.addr] : 8'hA5)
        ^ {7'h00, bad_en_i && mem_i.addr == bad_addr_i};
    dq_o = drv ? last_r : ~last_r;
    dq_z_o = !drv;
  end
endmodule : sft_ram_model

// ### tb/tb_top.sv
// self-checking bench for the pattern engine
`timescale 1ns/10ps
module tb_top;
  import sft_pkg::*;
  logic mclk_i = 0, rst_i = 1, start_i = 0, clear_fail_i = 0, bad_en = 0, stuck = 0;
  logic busy_o, done_o, fail_o, dz;
  logic [20:0] max_addr_i = 21'h000007, bad_addr = 21'h000000;
  logic [7:0] dq;
  sft_pat_e pattern_i = SFT_PAT_CHK;
  sft_mem_s mem_o, prev;
  sft_fail_s fail_info_o;
  int failures = 0, compares = 0, rd_cnt = 0, wr_cnt = 0;
  always #2.5 mclk_i = ~mclk_i;
  sft_tester u_sft_tester (.mclk_i, .rst_i, .start_i, .pattern_i, .max_addr_i, .clear_fail_i,
    .mem_o, .mem_data_i(dq), .mem_data_z_i(dz), .busy_o, .done_o, .fail_o, .fail_info_o);
  sft_ram_model u_sft_ram_model (.mem_i(mem_o), .bad_addr_i(bad_addr), .bad_en_i(bad_en),
    .stuck_i(stuck), .dq_o(dq), .dq_z_o(dz));
  ////////////////////////////////////////////////////////////////////////////////
  // count accesses on the falling edge, half a cycle after launch
  always @(negedge mclk_i)
  begin
    if (prev.write_low && !mem_o.write_low) wr_cnt++;
    if (prev.output_enable_low && !mem_o.output_enable_low) rd_cnt++;
    prev = mem_o;
  end
  function automatic logic [20:0] phys(input logic [20:0] a);
    return {a[0], a[20:1]};
  endfunction : phys
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk_v(input logic [36:0] got, input logic [36:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_v
  // start one run, with a refused second start mid-run, and wait bounded
  task automatic run(input sft_pat_e p);
    int n;
    @(negedge mclk_i) pattern_i = p;
    start_i = 1;
    wr_cnt = 0;
    rd_cnt = 0;
    @(negedge mclk_i) start_i = 0;
    repeat (3) @(negedge mclk_i);
    start_i = 1;
    pattern_i = SFT_PAT_CS;
    @(negedge mclk_i) start_i = 0;
    for (n = 0; n < 9000 && !done_o; n++) @(negedge mclk_i);
    if (!done_o)
    begin
      failures++;
      tally_and_finish();
    end
  endtask : run
  task automatic chk_fill(input logic [7:0] ev, input logic [7:0] od);
    for (int a = 0; a < 8; a++)
      chk_v(37'(u_sft_ram_model.mem_r[phys(21'(a))]), 37'(a[0] ? od : ev));
  endtask : chk_fill
  task automatic t_checker;
    run(SFT_PAT_CHK);
    chk_v(37'(wr_cnt), 37'd16);
    chk_v(37'(rd_cnt), 37'd16);
    chk_v(37'(fail_o), 37'd0);
    chk_fill(8'hAA, 8'h55);
  endtask : t_checker
  task automatic t_march;
    run(SFT_PAT_MARCH);
    chk_v(37'(wr_cnt), 37'd56);
    chk_v(37'(rd_cnt), 37'd56);
    chk_v(37'(fail_o), 37'd0);
    chk_fill(MARCH_DATA, MARCH_DATA);
  endtask : t_march
  // bit 0 flips on reads of logical 3
  task automatic t_solid_fault;
    bad_addr = phys(21'h000003);
    bad_en = 1;
    run(SFT_PAT_SOLID);
    chk_v(37'(fail_o), 37'd1);
    chk_v(fail_info_o, {21'h000003, ZERO_DATA, 8'h01});
    chk_v(37'(wr_cnt), 37'd16);
    chk_fill(ONES_DATA, ONES_DATA);
    @(negedge mclk_i) clear_fail_i = 1;
    bad_en = 0;
    @(negedge mclk_i) clear_fail_i = 0;
    chk_v(37'(fail_o), 37'd0);
  endtask : t_solid_fault
  // each float check alone, then against a ram that never lets go
  task automatic t_float;
    for (int s = 0; s < 4; s++)
    begin
      stuck = s[1];
      run(s[0] ? SFT_PAT_CS : SFT_PAT_OE);
      chk_v(37'(fail_o), 37'(s[1]));
      @(negedge mclk_i) clear_fail_i = 1;
      @(negedge mclk_i) clear_fail_i = 0;
    end
  endtask : t_float
  initial
  begin
    repeat (4) @(negedge mclk_i);
    rst_i = 0;
    t_checker();
    t_march();
    t_solid_fault();
    t_float();
    tally_and_finish();
  end
endmodule : tb_top
